// ---- idbx_consts.svh ----
// Named constants for the divide and bit-field extract unit.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef IDBX_CONSTS_SVH
`define IDBX_CONSTS_SVH

// APB byte addresses, one aligned word each
`define IDBX_ADDR_CTRL    12'h000
`define IDBX_ADDR_INSTR   12'h004
`define IDBX_ADDR_SRC1    12'h008
`define IDBX_ADDR_SRC2    12'h00c
`define IDBX_ADDR_RESULT  12'h010
`define IDBX_ADDR_STATUS  12'h014
`define IDBX_ADDR_MASK    12'h018
`define IDBX_ADDR_STATE   12'h01c

// Status and mask bit positions
`define IDBX_ST_DONE      0
`define IDBX_ST_INTDIV    1
`define IDBX_ST_FPUNIMP   2
`define IDBX_ST_BADOP     3
`define IDBX_ST_W         4

// Control bit positions and reset values
`define IDBX_CTRL_FPU_EN  0
`define IDBX_CTRL_RST     1'h0
`define IDBX_MASK_RST     4'h0

// Instruction fields
`define IDBX_OPC_HI       31
`define IDBX_OPC_LO       26
`define IDBX_DST_HI       25
`define IDBX_DST_LO       21
`define IDBX_SUB_HI       15
`define IDBX_SUB_LO       10
`define IDBX_WID_HI       9
`define IDBX_WID_LO       5
`define IDBX_OFF_HI       4
`define IDBX_OFF_LO       0
`define IDBX_IMM_HI       15

// Opcodes and sub-opcodes
`define IDBX_OPC_DIV_IMM  6'h1e
`define IDBX_OPC_DIVU_IMM 6'h1a
`define IDBX_OPC_BF_IMM   6'h3c
`define IDBX_OPC_TRIADIC  6'h3d
`define IDBX_SUB_DIV      6'h1e
`define IDBX_SUB_DIVU     6'h1a
`define IDBX_SUB_EXT      6'h24
`define IDBX_SUB_EXTU     6'h26
`define IDBX_WID_ZERO     5'h00

// Divider step count and data word width
`define IDBX_DIV_STEPS    6'h20
`define IDBX_WORD_BITS    6'h20

`endif

// ---- idbx_pkg.sv ----
// Types shared by the divide and bit-field extract unit.
// Assumes idbx_consts.svh is on the include path.
package idbx_pkg;
	// Sequencer states
	typedef enum logic [0:0] {
		IDBX_IDLE,
		IDBX_DIV
	} idbx_state_t;

	// Decoded operation
	typedef enum logic [2:0] {
		IDBX_OP_NONE,
		IDBX_OP_DIV,
		IDBX_OP_DIVU,
		IDBX_OP_EXT,
		IDBX_OP_EXTU
	} idbx_op_t;
endpackage : idbx_pkg

// ---- idbx_seq_model.sv ----
// Sequencer model: issues APB transfers into the unit on request of the bench.
// Assumes one pclk; the bench calls xfer and watches tmo.
`timescale 1ns/1ns
`default_nettype none

module idbx_seq_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic             tmo
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		tmo = 1'b0;
	end

	// One transfer: setup, then access held until pready is seen high, or released with tmo after 16 clocks without it
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 16) tmo <= 1'b1;
		// Released lines show a changed value, never the old one
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : idbx_seq_model

`default_nettype wire

// ---- idbx_top.sv ----
// Divide and bit-field extract execution unit with an APB register slave.
// Assumes a single 100 MHz pclk, an APB master and software sequencing.
//
// Notes on behaviour
// - Signed divide of source one by register or zero-extended immediate, quotient out.
// - Signed divide with zero divisor or negative operand raises integer-divide, no write.
// - Unsigned divide stores quotient; integer-divide only for a zero divisor.
// - Either divide with the float unit disabled raises float-unimplemented.
// - Signed divide decodes as opcode 011110 immediate or 111101 with sub 011110.
// - Unsigned divide decodes as opcode 011010 immediate or 111101 with sub 011010.
// - Bits 9 to 5 of triadic divides are ignored; software keeps them zero.
// - Signed extract takes width at offset from source one, sign-extended.
// - Unsigned extract takes width at offset from source one, zero-extended.
// - Triadic extract uses source two bits 9-5 as width, 4-0 as offset.
// - Signed field past bit 31 uses bit 31 as sign through the top.
// - Unsigned field past bit 31 fills the top with zeros.
// - Width zero means 32; signed extract becomes arithmetic right shift.
// - Unsigned extract with width zero becomes logical right shift.
// - Signed extract decodes 111100 sub 100100, or 111101 with bits 15-5 10010000000.
// - Unsigned extract decodes 111100 sub 100110, or 111101 sub 100110, zeros 9-5.
`timescale 1ns/1ns
`default_nettype none
`include "idbx_consts.svh"

module idbx_top #(
	parameter int DATA_W = 32
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq
);

	// Field of given width and offset, sign or zero extended
	function automatic logic [31:0] idbx_extract(
		input logic [31:0] src,
		input logic [4:0]  wid,
		input logic [4:0]  off,
		input logic        sgn
	);
		logic [31:0] mask;
		logic [31:0] fld;
		logic [5:0]  top;
		logic        sbit;
		mask = (wid == `IDBX_WID_ZERO) ? 32'hffffffff : ~(32'hffffffff << wid);
		fld  = (src >> off) & mask;
		top  = {1'b0, off} + {1'b0, wid};
		sbit = fld[wid - 5'h01];
		if (!sgn) begin
			idbx_extract = fld;
		end else if (wid == `IDBX_WID_ZERO || top > `IDBX_WORD_BITS) begin
			idbx_extract = 32'($signed(src) >>> off);
		end else begin
			idbx_extract = fld | (sbit ? ~mask : 32'h00000000);
		end
	endfunction : idbx_extract

	logic                     pready_q;
	logic                     pslverr_q;
	logic [DATA_W-1:0]        prdata_q;
	logic                     irq_q;
	logic                     fpu_en_q;
	logic [31:0]              instr_q;
	logic [31:0]              src1_q;
	logic [31:0]              src2_q;
	logic [31:0]              result_q;
	logic [`IDBX_ST_W-1:0]    status_q;
	logic [`IDBX_ST_W-1:0]    mask_q;
	logic                     wr_valid_q;
	logic [4:0]               dest_q;
	idbx_pkg::idbx_state_t    state_q;
	logic [31:0]              rem_q;
	logic [31:0]              dvd_q;
	logic [31:0]              dvs_q;
	logic [5:0]               cnt_q;

	// APB phase decode; the write or read takes effect when pready is seen
	wire                      acc_w   = psel && penable && pready_q;
	wire                      wr_en   = acc_w && pwrite;
	wire                      rd_en   = acc_w && !pwrite;
	wire                      a_ctrl  = (paddr == `IDBX_ADDR_CTRL);
	wire                      a_instr = (paddr == `IDBX_ADDR_INSTR);
	wire                      a_src1  = (paddr == `IDBX_ADDR_SRC1);
	wire                      a_src2  = (paddr == `IDBX_ADDR_SRC2);
	wire                      a_res   = (paddr == `IDBX_ADDR_RESULT);
	wire                      a_stat  = (paddr == `IDBX_ADDR_STATUS);
	wire                      a_mask  = (paddr == `IDBX_ADDR_MASK);
	wire                      a_state = (paddr == `IDBX_ADDR_STATE);
	wire                      mapped  = a_ctrl || a_instr || a_src1 || a_src2 ||
	                                    a_res || a_stat || a_mask || a_state;
	wire                      busy    = (state_q == idbx_pkg::IDBX_DIV);

	// Read data selection; reserved bits read as zero
	logic [DATA_W-1:0]        rd_mux;
	always_comb begin
		rd_mux = '0;
		if (a_ctrl) begin
			rd_mux[`IDBX_CTRL_FPU_EN] = fpu_en_q;
		end else if (a_instr) begin
			rd_mux = instr_q;
		end else if (a_src1) begin
			rd_mux = src1_q;
		end else if (a_src2) begin
			rd_mux = src2_q;
		end else if (a_res) begin
			rd_mux = result_q;
		end else if (a_stat) begin
			rd_mux[`IDBX_ST_W-1:0] = status_q;
		end else if (a_mask) begin
			rd_mux[`IDBX_ST_W-1:0] = mask_q;
		end else if (a_state) begin
			rd_mux[6:0] = {dest_q, wr_valid_q, busy};
		end
	end

	// APB answer: one wait state, error on unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !mapped;
			if (psel && penable && !pready_q && !pwrite) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// Instruction decode of the word being written; starts only when idle
	wire                      start   = wr_en && a_instr && !busy;
	wire [31:0]               iw      = pwdata[31:0];
	wire [5:0]                opc     = iw[`IDBX_OPC_HI:`IDBX_OPC_LO];
	wire [5:0]                sub     = iw[`IDBX_SUB_HI:`IDBX_SUB_LO];
	wire                      tri_w   = (opc == `IDBX_OPC_TRIADIC);
	wire                      wz_w    = (iw[`IDBX_WID_HI:`IDBX_WID_LO] == `IDBX_WID_ZERO);
	// Bits 9 to 5 are not looked at in triadic divides
	wire                      dec_div  = (opc == `IDBX_OPC_DIV_IMM) ||
	                                     (tri_w && sub == `IDBX_SUB_DIV);
	wire                      dec_divu = (opc == `IDBX_OPC_DIVU_IMM) ||
	                                     (tri_w && sub == `IDBX_SUB_DIVU);
	wire                      bf_imm   = (opc == `IDBX_OPC_BF_IMM);
	wire                      dec_ext  = (bf_imm || (tri_w && wz_w)) &&
	                                     sub == `IDBX_SUB_EXT;
	wire                      dec_extu = (bf_imm || (tri_w && wz_w)) &&
	                                     sub == `IDBX_SUB_EXTU;
	wire [31:0]               imm_w    = {16'h0000, iw[`IDBX_IMM_HI:0]};
	wire [31:0]               divisor  = tri_w ? src2_q : imm_w;
	// Triadic extract takes width and offset from source two
	wire [4:0]                ext_wid  = tri_w ? src2_q[`IDBX_WID_HI:`IDBX_WID_LO] :
	                                             iw[`IDBX_WID_HI:`IDBX_WID_LO];
	wire [4:0]                ext_off  = tri_w ? src2_q[`IDBX_OFF_HI:`IDBX_OFF_LO] :
	                                             iw[`IDBX_OFF_HI:`IDBX_OFF_LO];
	wire [31:0]               ext_res  = idbx_extract(src1_q, ext_wid, ext_off, dec_ext);
	wire                      is_div   = dec_div || dec_divu;
	wire                      fp_exc   = is_div && !fpu_en_q;
	wire                      dz_exc   = is_div && fpu_en_q && divisor == 32'h00000000;
	wire                      neg_exc  = dec_div && fpu_en_q &&
	                                     (src1_q[31] || divisor[31]);
	wire                      int_exc  = dz_exc || neg_exc;
	wire                      div_go   = start && is_div && !fp_exc && !int_exc;

	// Restoring divider step
	wire [32:0]               trial    = {rem_q, dvd_q[31]};
	wire [32:0]               diff     = trial - {1'b0, dvs_q};
	wire                      ge       = !diff[32];
	wire                      div_end  = busy && cnt_q == `IDBX_DIV_STEPS - 6'h01;

	// Events that set sticky status bits
	logic [`IDBX_ST_W-1:0]    ev_set;
	always_comb begin
		ev_set = '0;
		ev_set[`IDBX_ST_DONE]    = (start && !div_go) || div_end;
		ev_set[`IDBX_ST_INTDIV]  = start && int_exc;
		ev_set[`IDBX_ST_FPUNIMP] = start && fp_exc;
		ev_set[`IDBX_ST_BADOP]   = start && !is_div && !dec_ext && !dec_extu;
	end
	wire [`IDBX_ST_W-1:0]     st_clr   = (rd_en && a_stat) ? '1 : '0;

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fpu_en_q <= `IDBX_CTRL_RST;
			mask_q   <= `IDBX_MASK_RST;
			src1_q   <= 32'h00000000;
			src2_q   <= 32'h00000000;
			instr_q  <= 32'h00000000;
		end else begin
			if (wr_en && a_ctrl) begin
				fpu_en_q <= pwdata[`IDBX_CTRL_FPU_EN];
			end
			if (wr_en && a_mask) begin
				mask_q <= pwdata[`IDBX_ST_W-1:0];
			end
			if (wr_en && a_src1) begin
				src1_q <= pwdata[31:0];
			end
			if (wr_en && a_src2) begin
				src2_q <= pwdata[31:0];
			end
			if (start) begin
				instr_q <= iw;
			end
		end
	end

	// Status: a new event wins over the clearing read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= '0;
			irq_q    <= 1'b0;
		end else begin
			status_q <= (status_q & ~st_clr) | ev_set;
			irq_q    <= |(status_q & mask_q);
		end
	end

	// Sequencer: extract in one cycle, divide over 32 steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= idbx_pkg::IDBX_IDLE;
			result_q   <= 32'h00000000;
			wr_valid_q <= 1'b0;
			dest_q     <= 5'h00;
			rem_q      <= 32'h00000000;
			dvd_q      <= 32'h00000000;
			dvs_q      <= 32'h00000000;
			cnt_q      <= 6'h00;
		end else begin
			case (state_q)
				idbx_pkg::IDBX_IDLE: begin
					if (start) begin
						dest_q     <= iw[`IDBX_DST_HI:`IDBX_DST_LO];
						wr_valid_q <= dec_ext || dec_extu;
						if (dec_ext || dec_extu) begin
							result_q <= ext_res;
						end
						if (div_go) begin
							state_q <= idbx_pkg::IDBX_DIV;
							rem_q   <= 32'h00000000;
							dvd_q   <= src1_q;
							dvs_q   <= divisor;
							cnt_q   <= 6'h00;
						end
					end
				end
				idbx_pkg::IDBX_DIV: begin
					rem_q <= ge ? diff[31:0] : trial[31:0];
					dvd_q <= {dvd_q[30:0], ge};
					cnt_q <= cnt_q + 6'h01;
					if (div_end) begin
						result_q   <= {dvd_q[30:0], ge};
						wr_valid_q <= 1'b1;
						state_q    <= idbx_pkg::IDBX_IDLE;
					end
				end
				default: begin
					state_q <= idbx_pkg::IDBX_IDLE;
				end
			endcase
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;

	// Helper snapshot of divide operands for checking
	logic [31:0] chk_a_q;
	logic [31:0] chk_b_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_a_q <= 32'h00000000;
			chk_b_q <= 32'h00000001;
		end else if (div_go) begin
			chk_a_q <= src1_q;
			chk_b_q <= divisor;
		end
	end

	// Independent field reference: lift the field to the top, then shift it back down
	wire [5:0]                chk_up   = `IDBX_WORD_BITS - {1'b0, ext_off} - {1'b0, ext_wid};
	wire [5:0]                chk_dn   = `IDBX_WORD_BITS - {1'b0, ext_wid};
	wire                      chk_in   = ext_wid != `IDBX_WID_ZERO && chk_up < `IDBX_WORD_BITS;
	wire [31:0]               chk_sfld = 32'($signed(src1_q << chk_up) >>> chk_dn);
	wire [31:0]               chk_ufld = (src1_q << chk_up) >> chk_dn;
	// Sign fill for a signed field that runs past the top bit
	wire [31:0]               chk_fill = src1_q[31] ? ~(32'hffffffff >> ext_off) : 32'h00000000;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	div_quotient_a: assert property (
		div_go |-> ##33 (result_q == chk_a_q / chk_b_q) && wr_valid_q && !busy)
		else $error("divide quotient wrong or late");

	div_neg_exc_a: assert property (
		start && dec_div && fpu_en_q && src1_q[31] |=>
		status_q[`IDBX_ST_INTDIV] && !wr_valid_q && !busy)
		else $error("negative signed divide not trapped");

	divu_zero_exc_a: assert property (
		start && dec_divu && fpu_en_q && divisor == 32'h00000000 |=>
		status_q[`IDBX_ST_INTDIV] && $stable(result_q))
		else $error("zero divisor not trapped");

	fpu_off_exc_a: assert property (
		start && is_div && !fpu_en_q |=>
		status_q[`IDBX_ST_FPUNIMP] && !status_q[`IDBX_ST_INTDIV] && !busy)
		else $error("disabled float unit not trapped");

	ext_ashift_a: assert property (
		start && dec_ext && ext_wid == `IDBX_WID_ZERO |=>
		result_q == 32'($signed($past(src1_q)) >>> $past(ext_off)))
		else $error("signed extract width zero not a shift");

	extu_lshift_a: assert property (
		start && dec_extu && ext_wid == `IDBX_WID_ZERO |=>
		result_q == ($past(src1_q) >> $past(ext_off)))
		else $error("unsigned extract width zero not a shift");

	ext_no_exc_a: assert property (
		start && (dec_ext || dec_extu) |=>
		wr_valid_q && !busy && status_q[`IDBX_ST_DONE])
		else $error("extract did not complete cleanly");

	set_wins_a: assert property (
		div_end && rd_en && a_stat |=> status_q[`IDBX_ST_DONE])
		else $error("status event lost to clearing read");

	irq_level_a: assert property (
		(|(status_q & mask_q)) [*2] |-> irq_q)
		else $error("unmasked status without interrupt");

	busy_refuse_a: assert property (
		busy && wr_en && a_instr |=> $stable(instr_q))
		else $error("instruction accepted while dividing");

	ext_field_a: assert property (
		start && dec_ext && chk_in |=> result_q == $past(chk_sfld))
		else $error("signed extract field wrong");

	extu_field_a: assert property (
		start && dec_extu && chk_in |=> result_q == $past(chk_ufld))
		else $error("unsigned extract field wrong");

	ext_past_top_a: assert property (
		start && dec_ext && ext_wid != `IDBX_WID_ZERO && !chk_in |=>
		result_q == (($past(src1_q) >> $past(ext_off)) | $past(chk_fill)))
		else $error("signed field past top not sign filled");

	extu_past_top_a: assert property (
		start && dec_extu && ext_wid != `IDBX_WID_ZERO && !chk_in |=>
		result_q == ($past(src1_q) >> $past(ext_off)))
		else $error("unsigned field past top not zero filled");

	div_runs_a: assert property (
		start && dec_div && fpu_en_q && divisor != 32'h00000000 &&
		!src1_q[31] && !divisor[31] |=> busy)
		else $error("valid signed divide did not start");

	divu_runs_a: assert property (
		start && dec_divu && fpu_en_q && divisor != 32'h00000000 |=> busy)
		else $error("valid unsigned divide did not start");

endmodule : idbx_top
`default_nettype wire

// ---- int_divide_bitfield_extract_bench.sv ----
// Self-checking bench for the divide and bit-field extract unit.
// Assumes idbx_consts.svh on the include path and the sequencer model.
`timescale 1ns/1ns
`default_nettype none
`include "idbx_consts.svh"

`define IDBX_CHK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("BAD at %0t got %h expected %h", $time, (got), (exp)); \
	end \
end

module int_divide_bitfield_extract_bench;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic        e;
	} idbx_note_t;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        tmo;
	logic        mask_on;
	logic        fpu_on;
	logic [31:0] last_res;
	logic [31:0] a;
	logic [31:0] b;
	idbx_note_t  cur;
	idbx_note_t  note_q[$];
	int          err_total;
	int          checks_done;
	int          i;

	idbx_top #(.DATA_W(32)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq)
	);

	idbx_seq_model u_seq (
		.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tmo(tmo)
	);

	// Clock, 10 ns period
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Read monitor: each completed read is matched with the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (note_q.size() == 0) begin
				`IDBX_CHK(1'b0, 1'b1)
			end else begin
				cur = note_q.pop_front();
				`IDBX_CHK(prdata & cur.m, cur.d)
				`IDBX_CHK(pslverr, cur.e)
			end
		end
	end

	// A stuck bus transfer ends the run
	always @(posedge pclk) begin
		if (tmo === 1'b1) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		u_seq.xfer(1'b1, ad, d);
	endtask : wr

	task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic [31:0] m,
		input logic se);
		note_q.push_back('{e & m, m, se});
		u_seq.xfer(1'b0, ad, 32'h0);
	endtask : rd

	// Load operands, start, wait for the event, then check status, result, state
	task automatic run_op(input logic [31:0] ins, s1, s2, input logic [3:0] st,
		input logic [31:0] res);
		int k;
		logic ok;
		ok = (st == 4'h1);
		wr(`IDBX_ADDR_SRC1, s1);
		wr(`IDBX_ADDR_SRC2, s2);
		wr(`IDBX_ADDR_INSTR, ins);
		if (mask_on) begin
			for (k = 0; k < 60 && irq !== 1'b1; k++) @(posedge pclk);
			if (k == 60) begin
				err_total++;
				tally_and_finish();
			end
		end else begin
			repeat (40) @(posedge pclk);
			`IDBX_CHK(irq, 1'b0)
		end
		if (ok) last_res = res;
		rd(`IDBX_ADDR_STATUS, {28'h0, st}, {28'h0, 3'h7, ok}, 1'b0);
		rd(`IDBX_ADDR_STATUS, 32'h0, 32'hf, 1'b0);
		rd(`IDBX_ADDR_RESULT, last_res, 32'hffffffff, 1'b0);
		rd(`IDBX_ADDR_STATE, {25'h0, ins[25:21], ok, 1'b0}, 32'h7f, 1'b0);
	endtask : run_op

	task automatic do_div(input logic sg, trd, input logic [31:0] s1, s2);
		logic [31:0] dv;
		logic [31:0] ins;
		logic [5:0]  code;
		logic [3:0]  st;
		code = sg ? `IDBX_OPC_DIV_IMM : `IDBX_OPC_DIVU_IMM;
		dv = trd ? s2 : {16'h0, s2[15:0]};
		// Loose bits 9-5 of the triadic form carry noise on purpose
		ins = trd ? {`IDBX_OPC_TRIADIC, 5'(i), 5'h1, code, 5'($urandom), 5'h2}
			: {code, 5'(i), 5'h1, s2[15:0]};
		st = !fpu_on ? 4'h4 : (dv == 0 || (sg && (s1[31] || dv[31]))) ? 4'h2 : 4'h1;
		run_op(ins, s1, s2, st, s1 / dv);
	endtask : do_div

	function automatic logic [31:0] ext_ref(logic [31:0] s, logic [4:0] w, o, logic sg);
		logic [63:0] t;
		logic [31:0] r;
		t = sg ? {{32{s[31]}}, s} : {32'h0, s};
		t = t >> o;
		r = t[31:0];
		if (w != 5'h0 && ({1'b0, w} + {1'b0, o}) <= 6'h20) begin
			for (int j = 0; j < 32; j++) if (j >= w) r[j] = sg ? r[w - 1] : 1'b0;
		end
		return r;
	endfunction : ext_ref

	task automatic do_ext(input logic sg, trd, input logic [31:0] s1, input logic [4:0] w, o);
		logic [31:0] s2;
		logic [31:0] ins;
		logic [5:0]  sub;
		sub = sg ? `IDBX_SUB_EXT : `IDBX_SUB_EXTU;
		s2 = $urandom;
		s2[9:0] = {w, o};
		ins = trd ? {`IDBX_OPC_TRIADIC, 5'(i), 5'h1, sub, 5'h0, 5'h2}
			: {`IDBX_OPC_BF_IMM, 5'(i), 5'h1, sub, w, o};
		run_op(ins, s1, s2, 4'h1, ext_ref(s1, w, o, sg));
	endtask : do_ext

	// Main sequence
	initial begin
		presetn = 1'b0;
		err_total = 0;
		checks_done = 0;
		mask_on = 1'b0;
		fpu_on = 1'b0;
		last_res = 32'h0;
		i = 0;
		void'($urandom(32'hab086bb7));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 8; i++) rd(12'(4 * i), 32'h0, 32'hffffffff, 1'b0);
		rd(12'h020, 32'h0, 32'hffffffff, 1'b1);
		do_div(1'b1, 1'b0, 32'h64, 32'h5);
		wr(`IDBX_ADDR_MASK, 32'hf);
		mask_on = 1'b1;
		rd(`IDBX_ADDR_MASK, 32'hf, 32'hffffffff, 1'b0);
		do_div(1'b0, 1'b1, 32'h64, 32'h0);
		wr(`IDBX_ADDR_CTRL, 32'h1);
		fpu_on = 1'b1;
		for (i = 0; i < 12; i++) begin
			a = $urandom;
			b = $urandom;
			do_div(1'b1, i[0], a & 32'h7fffffff, (b & 32'h7fff) | 32'h1);
			do_div(1'b0, i[0], a, b >> i);
			do_ext(1'b1, i[0], a, 5'(b), 5'(b >> 5));
			do_ext(1'b0, i[0], a, 5'(b >> 10), 5'(b >> 15));
		end
		do_div(1'b1, 1'b1, 32'h80000000, 32'h3);
		do_div(1'b1, 1'b1, 32'h40, 32'hfffffffe);
		do_div(1'b1, 1'b0, 32'h40, 32'h0);
		do_div(1'b0, 1'b1, 32'hfffffff0, 32'h0);
		do_div(1'b0, 1'b1, 32'hfffffff0, 32'h10);
		do_ext(1'b1, 1'b0, 32'h80f00000, 5'h0, 5'h7);
		do_ext(1'b0, 1'b1, 32'h80f00000, 5'h0, 5'h7);
		do_ext(1'b1, 1'b1, 32'h90000000, 5'h8, 5'h1c);
		do_ext(1'b0, 1'b0, 32'h90000000, 5'h8, 5'h1c);
		run_op(32'h0, 32'h1, 32'h1, 4'h8, 32'h0);
		// Start 1/1, try a start while busy, then poll so the eighth transfer meets the end
		wr(`IDBX_ADDR_INSTR, {`IDBX_OPC_DIVU_IMM, 5'h0, 5'h1, 16'h0001});
		wr(`IDBX_ADDR_INSTR, 32'h0);
		for (i = 0; i < 7; i++) rd(`IDBX_ADDR_STATUS, 32'h0, 32'hf, 1'b0);
		rd(`IDBX_ADDR_STATUS, 32'h1, 32'hf, 1'b0);
		rd(`IDBX_ADDR_RESULT, 32'h1, 32'hffffffff, 1'b0);
		rd(`IDBX_ADDR_INSTR, {`IDBX_OPC_DIVU_IMM, 5'h0, 5'h1, 16'h0001}, 32'hffffffff, 1'b0);
		repeat (4) @(posedge pclk);
		`IDBX_CHK(note_q.size(), 0)
		tally_and_finish();
	end
endmodule : int_divide_bitfield_extract_bench

`default_nettype wire
